// ### core/lsm_map.svh
`ifndef LSM_MAP_SVH
`define LSM_MAP_SVH
// What this block does
// - enable bit drives selected input to test pins
// - address field picks the compared input pair
// - select 0 shows first signal, normal polarity
// - select 1 shows second signal, inverted
// - 0x60 routes port B bit 15 out
// - 0x61 routes data clock out, inverted
// - no address pairs port A bit 0 with clock
// - disable bit turns linearization off
// - gain field selects linearization strength

// register offsets on the serial port
`define LSM_OFS_LIN       7'h07
`define LSM_OFS_MUX       7'h18
// reset values
`define LSM_LIN_RST       8'h00
`define LSM_MUX_RST       8'h00
// field positions
`define LSM_LINEARIZE_DISABLE_BIT   0
`define LSM_LINEARIZE_GAIN_MSB    3
`define LSM_LINEARIZE_GAIN_LSB    1
`define LSM_MUX_EN_BIT    6
`define LSM_MUX_ADR_MSB   5
`define LSM_MUX_ADR_LSB   1
`define LSM_MUX_SEL_BIT   0
// serial frame: 16 bits, command in the first 8
`define LSM_CMD_LAST      4'h7
`define LSM_FRAME_LAST    4'hf
// pair address landmarks
`define LSM_ADR_BRIDGE    5'h0f
`define LSM_ADR_CLK_PAIR  5'h10
// positions in the sampled input vector
`define LSM_IDX_B0        6'h00
`define LSM_IDX_B15       6'h0f
`define LSM_IDX_A0        6'h10
`define LSM_IDX_A15       6'h1f
`define LSM_IDX_DCK       6'h20
// linearization strength in percent
`define LSM_PCT_050       8'h32
`define LSM_PCT_063       8'h3f
`define LSM_PCT_075       8'h4b
`define LSM_PCT_088       8'h58
`define LSM_PCT_100       8'h64
`define LSM_PCT_113       8'h71
`define LSM_PCT_125       8'h7d
`define LSM_PCT_138       8'h8a
`endif

// ### core/lsm_pkg.sv
package lsm_pkg;
  typedef logic [4:0] lsm_pair_addr_t;   // mux pair address
  typedef logic [5:0] lsm_idx_t;         // index into sampled inputs
  typedef logic [7:0] lsm_byte_t;        // one register byte
  // linearization gain codes
  typedef enum logic [2:0] {
    LSM_GN_075 = 3'b000,
    LSM_GN_088 = 3'b001,
    LSM_GN_100 = 3'b010,
    LSM_GN_113 = 3'b011,
    LSM_GN_125 = 3'b100,
    LSM_GN_138 = 3'b101,
    LSM_GN_050 = 3'b110,
    LSM_GN_063 = 3'b111
  } lsm_gain_t;
endpackage : lsm_pkg

// ### core/lsm_skew_mux.sv
`timescale 1ns/1ps
`include "lsm_map.svh"
module lsm_skew_mux
  import lsm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_b,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  input  wire logic        lvds_data_clock_in,
  input  wire logic [15:0] port_a_lvds_in,
  input  wire logic [15:0] port_b_lvds_in,
  output logic             test_output_pair_p,
  output logic             test_output_pair_n,
  output logic             test_output_pair_oe,
  output logic             linearize_disable,
  output lsm_gain_t        linearize_gain,
  output lsm_byte_t        linearize_strength_pct
);

  ////////////////////////////////////////////////////////////////////////////
  // serial port side, clocked by spi_sck
  ////////////////////////////////////////////////////////////////////////////
  logic       frame_rst_b;   // frame reset: chip reset or deselect
  logic [3:0] bit_cnt_reg;   // rising edges seen in this frame
  logic [6:0] shift_reg;     // incoming bits
  lsm_byte_t  cmd_reg;       // read flag and address
  lsm_byte_t  lin_reg;       // linearization control register
  lsm_byte_t  mux_reg;       // skew test mux control register
  logic       wr_tgl_reg;    // flips on every register write
  lsm_byte_t  rd_byte;       // byte selected for readback

  // sck stops between frames, so the frame ends by deselect
  assign frame_rst_b = rst_b & ~spi_cs_b;

  // shift in command and data, msb first
  always_ff @(posedge spi_sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 7'h00;
      cmd_reg     <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg   <= {shift_reg[5:0], spi_sdi};
      if (bit_cnt_reg == `LSM_CMD_LAST) begin
        cmd_reg <= {shift_reg, spi_sdi};  // bit 7 high means read
      end
    end
  end

  // commit a write on the last bit of the frame
  always_ff @(posedge spi_sck or negedge rst_b) begin
    if (!rst_b) begin
      lin_reg    <= `LSM_LIN_RST;
      mux_reg    <= `LSM_MUX_RST;
      wr_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == `LSM_FRAME_LAST && !cmd_reg[7]) begin
      if (cmd_reg[6:0] == `LSM_OFS_LIN) begin
        lin_reg    <= {shift_reg, spi_sdi};
        wr_tgl_reg <= ~wr_tgl_reg;
      end else if (cmd_reg[6:0] == `LSM_OFS_MUX) begin
        mux_reg    <= {shift_reg, spi_sdi};
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // readback mux, unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (cmd_reg[6:0] == `LSM_OFS_LIN) begin
      rd_byte = lin_reg;
    end else if (cmd_reg[6:0] == `LSM_OFS_MUX) begin
      rd_byte = mux_reg;
    end
  end

  // drive read data on falling edges of the data phase
  always_ff @(negedge spi_sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo_oe <= 1'b1;
      if (cmd_reg[7] && bit_cnt_reg[3]) begin
        spi_sdo <= rd_byte[~bit_cnt_reg[2:0]];
      end else begin
        spi_sdo <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossing of register contents into the clk domain
  ////////////////////////////////////////////////////////////////////////////
  logic tgl_s1_reg;   // first synchroniser stage
  logic tgl_s2_reg;   // second synchroniser stage
  logic tgl_s3_reg;   // edge detect history
  logic upd;          // one-cycle pulse: new register contents

  // toggle synchroniser; words are stable long before the edge lands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= wr_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  assign upd = tgl_s2_reg ^ tgl_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // captured control fields
  ////////////////////////////////////////////////////////////////////////////
  logic           mux_en_q;    // test output enable
  lsm_pair_addr_t mux_addr_q;  // pair address
  logic           mux_sel_q;   // first or second signal of pair

  // take the mux fields on each update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_en_q   <= 1'b0;
      mux_addr_q <= 5'h00;
      mux_sel_q  <= 1'b0;
    end else if (upd) begin
      mux_en_q   <= mux_reg[`LSM_MUX_EN_BIT];
      mux_addr_q <= mux_reg[`LSM_MUX_ADR_MSB:`LSM_MUX_ADR_LSB];
      mux_sel_q  <= mux_reg[`LSM_MUX_SEL_BIT];
    end
  end

  // linearization control outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linearize_disable <= 1'b0;
      linearize_gain    <= LSM_GN_075;
    end else if (upd) begin
      linearize_disable <= lin_reg[`LSM_LINEARIZE_DISABLE_BIT];
      linearize_gain    <= lsm_gain_t'(lin_reg[`LSM_LINEARIZE_GAIN_MSB:`LSM_LINEARIZE_GAIN_LSB]);
    end
  end

  // strength in percent for the correction stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linearize_strength_pct <= `LSM_PCT_075;
    end else begin
      unique case (linearize_gain)
        LSM_GN_050: linearize_strength_pct <= `LSM_PCT_050;
        LSM_GN_063: linearize_strength_pct <= `LSM_PCT_063;
        LSM_GN_075: linearize_strength_pct <= `LSM_PCT_075;
        LSM_GN_088: linearize_strength_pct <= `LSM_PCT_088;
        LSM_GN_100: linearize_strength_pct <= `LSM_PCT_100;
        LSM_GN_113: linearize_strength_pct <= `LSM_PCT_113;
        LSM_GN_125: linearize_strength_pct <= `LSM_PCT_125;
        LSM_GN_138: linearize_strength_pct <= `LSM_PCT_138;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input sampling and pair selection
  ////////////////////////////////////////////////////////////////////////////
  logic [32:0] lv_s1_reg;  // first stage: clock, port a, port b
  logic [32:0] lv_s2_reg;  // second stage, read by the mux
  lsm_idx_t    fst_idx;    // first signal of addressed pair
  lsm_idx_t    snd_idx;    // second signal of addressed pair
  logic        mux_bit;    // value headed for the test pins

  // two-stage sampling of the pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lv_s1_reg <= 33'h0;
      lv_s2_reg <= 33'h0;
    end else begin
      lv_s1_reg <= {lvds_data_clock_in, port_a_lvds_in, port_b_lvds_in};
      lv_s2_reg <= lv_s1_reg;
    end
  end

  // chain of neighbours: b0..b15, a15-b0, b15-clock, a0..a15
  always_comb begin
    if (mux_addr_q < `LSM_ADR_BRIDGE) begin
      fst_idx = {1'b0, mux_addr_q};
      snd_idx = {1'b0, mux_addr_q} + 6'h01;
    end else if (mux_addr_q == `LSM_ADR_BRIDGE) begin
      fst_idx = `LSM_IDX_A15;
      snd_idx = `LSM_IDX_B0;
    end else if (mux_addr_q == `LSM_ADR_CLK_PAIR) begin
      fst_idx = `LSM_IDX_B15;
      snd_idx = `LSM_IDX_DCK;
    end else begin
      fst_idx = {1'b0, mux_addr_q} - 6'h01;
      snd_idx = {1'b0, mux_addr_q};
    end
  end

  // select 1 shows the second signal inverted
  assign mux_bit = mux_sel_q ? ~lv_s2_reg[snd_idx] : lv_s2_reg[fst_idx];

  // differential test output, quiet while disabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      test_output_pair_p  <= 1'b0;
      test_output_pair_n  <= 1'b0;
      test_output_pair_oe <= 1'b0;
    end else begin
      test_output_pair_oe <= mux_en_q;
      test_output_pair_p  <= mux_en_q & mux_bit;
      test_output_pair_n  <= mux_en_q & ~mux_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_en_drives;
    mux_en_q |=> test_output_pair_oe && (test_output_pair_n == !test_output_pair_p);
  endproperty
  a_en_drives: assert property (p_en_drives) else $error("mux enable not driving");

  property p_addr_zero;
    mux_en_q && mux_addr_q == 5'h00 && !mux_sel_q |=> test_output_pair_p == $past(lv_s2_reg[0]);
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("pair 0 wrong");

  property p_first_sig;
    mux_en_q && !mux_sel_q |=> test_output_pair_p == $past(lv_s2_reg[fst_idx]);
  endproperty
  a_first_sig: assert property (p_first_sig) else $error("first signal wrong");

  property p_second_inv;
    mux_en_q && mux_sel_q |=> test_output_pair_p != $past(lv_s2_reg[snd_idx]);
  endproperty
  a_second_inv: assert property (p_second_inv) else $error("second not inverted");

  property p_b15_route;
    mux_en_q && mux_addr_q == 5'h10 && !mux_sel_q
      |=> test_output_pair_p == $past(lv_s2_reg[15]);
  endproperty
  a_b15_route: assert property (p_b15_route) else $error("b15 not routed");

  property p_clk_route;
    mux_en_q && mux_addr_q == 5'h10 && mux_sel_q
      |=> test_output_pair_p == !$past(lv_s2_reg[32]);
  endproperty
  a_clk_route: assert property (p_clk_route) else $error("clock not inverted");

  property p_no_a0_clk;
    !((fst_idx == `LSM_IDX_A0 && snd_idx == `LSM_IDX_DCK) ||
      (snd_idx == `LSM_IDX_A0 && fst_idx == `LSM_IDX_DCK));
  endproperty
  a_no_a0_clk: assert property (p_no_a0_clk) else $error("a0 paired with clock");

  property p_linearize_disable;
    upd |=> ##1 linearize_disable == $past(lin_reg[0], 2);
  endproperty
  a_linearize_disable: assert property (p_linearize_disable) else $error("disable not taken");

  property p_gain_pct;
    (linearize_gain == LSM_GN_075 |=> linearize_strength_pct == 8'h4b) and
    (linearize_gain == LSM_GN_063 |=> linearize_strength_pct == 8'h3f) and
    (linearize_gain == LSM_GN_088 |=> linearize_strength_pct == 8'h58) and
    (linearize_gain == LSM_GN_100 |=> linearize_strength_pct == 8'h64) and
    (linearize_gain == LSM_GN_113 |=> linearize_strength_pct == 8'h71) and
    (linearize_gain == LSM_GN_050 |=> linearize_strength_pct == 8'h32);
  endproperty
  a_gain_pct: assert property (p_gain_pct) else $error("gain percent wrong");

  property p_fields;
    upd |=> mux_en_q == $past(mux_reg[6]) && mux_addr_q == $past(mux_reg[5:1])
      && mux_sel_q == $past(mux_reg[0]);
  endproperty
  a_fields: assert property (p_fields) else $error("mux fields misplaced");

  // a disabled mux leaves all three test pins low
  property p_dis_quiet;
    !mux_en_q |=> !test_output_pair_oe && !test_output_pair_p && !test_output_pair_n;
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("test pins not quiet");

  // an update carries the gain field out of the register
  property p_gain_take;
    upd |=> linearize_gain == $past(lin_reg[3:1]);
  endproperty
  a_gain_take: assert property (p_gain_take) else $error("gain not taken");

  // one write reaches the clk side as a single-cycle pulse
  property p_upd_single;
    upd |=> !upd;
  endproperty
  a_upd_single: assert property (p_upd_single) else $error("update pulse too long");

  c_clk_pair: cover property (mux_en_q && mux_addr_q == 5'h10 && mux_sel_q);
  c_b15_pair: cover property (mux_en_q && mux_addr_q == 5'h10 && !mux_sel_q);
  c_lin_off:  cover property (linearize_disable && linearize_gain == LSM_GN_050);
  // bridge pair and the port a chain reached with the mux on
  c_bridge:   cover property (mux_en_q && mux_addr_q == 5'h0f);
  c_a_chain:  cover property (mux_en_q && mux_addr_q > 5'h10 && mux_sel_q);

endmodule : lsm_skew_mux

// ### testbench/lsm_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host side: serial master, mode 0, clock parked low between frames
module lsm_host_model (
  output logic      spi_sck,
  output logic      spi_cs_b,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  localparam realtime HALF = 62.5;  // half of the 125 ns link period
  // idle: deselected, clock still
  initial begin
    spi_sck  = 1'b0;
    spi_cs_b = 1'b1;
    spi_sdi  = 1'b1;
  end
  // one frame msb first; fewer than 16 bits aborts it
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd,
                      input int nbits, output logic [7:0] rdat);
    logic [15:0] sh;
    sh       = {rd, adr, wd};
    rdat     = 8'h00;
    spi_cs_b = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_sdi = sh[15 - i];
      #HALF spi_sck = 1'b1;
      if (i >= 8) rdat = {rdat[6:0], spi_sdo};
      #HALF spi_sck = 1'b0;
    end
    spi_cs_b = 1'b1;
    spi_sdi  = ~spi_sdi;  // released line shows no stale bit
    #(4 * HALF);          // gap keeps writes at least 10 clk apart
  endtask : xfer
endmodule : lsm_host_model

// ### testbench/lvds_skew_test_mux_ctrl_tb.sv
`timescale 1ns/1ps
module lvds_skew_test_mux_ctrl_tb;
  import lsm_pkg::*;
  logic        clk, rst_b, spi_sck, spi_cs_b, spi_sdi, spi_sdo, spi_sdo_oe;
  logic        lvds_data_clock_in, test_output_pair_p, test_output_pair_n;
  logic        test_output_pair_oe, linearize_disable;
  logic [15:0] port_a_lvds_in, port_b_lvds_in, obs_val, exp_v;
  lsm_gain_t   linearize_gain;
  lsm_byte_t   linearize_strength_pct, rd, r, v;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  logic [15:0] exp_q [$];  // expected results, oldest first
  event        obs_ev;
  logic [7:0]  pct_tab [8] = '{8'h4b, 8'h58, 8'h64, 8'h71, 8'h7d, 8'h8a, 8'h32, 8'h3f};
  logic [4:0]  ad_tab [6]  = '{5'h00, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h1f};
  lsm_skew_mux lsm_skew_mux_i (.clk, .rst_b, .spi_sck, .spi_cs_b, .spi_sdi, .spi_sdo,
    .spi_sdo_oe, .lvds_data_clock_in, .port_a_lvds_in, .port_b_lvds_in,
    .test_output_pair_p, .test_output_pair_n, .test_output_pair_oe,
    .linearize_disable, .linearize_gain, .linearize_strength_pct);
  lsm_host_model host_i (.spi_sck, .spi_cs_b, .spi_sdi, .spi_sdo);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR %0t run timed out", $time);
      summarize();
    end
  end
  // watcher: compares each observation with the oldest note
  always @(obs_ev) begin
    tests_run++;
    exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx;
    if (exp_v !== obs_val) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, obs_val, exp_v);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    obs_val = g;
    ->obs_ev;
    #1;
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_i.xfer(1'b0, a, d, 16, rd);
  endtask : wr
  // read a register; output enable must be up mid frame and down after it
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic oe_mid;  // output enable seen in mid frame
    oe_mid = 1'b0;
    fork
      host_i.xfer(1'b1, a, 8'h00, 16, rd);
      #1200 oe_mid = spi_sdo_oe;
    join
    check({6'h00, 2'b10, e}, {6'h00, oe_mid, spi_sdo_oe, rd});
  endtask : rdchk
  // status word: oe, disable, gain, percent
  task automatic stat_chk(input logic [15:0] e);
    check(e, {3'b000, test_output_pair_oe, linearize_disable, linearize_gain,
              linearize_strength_pct});
  endtask : stat_chk
  // expected {oe, n, p} from register value and held inputs
  function automatic logic [2:0] mux_exp(input logic [7:0] rv, input logic ck,
                                         input logic [15:0] a, input logic [15:0] b);
    logic [4:0] ad;
    logic       f;
    logic       s;
    ad = rv[5:1];
    if (ad < 5'd15) begin
      f = b[ad];
      s = b[ad + 5'd1];
    end else if (ad == 5'd15) begin
      f = a[15];
      s = b[0];
    end else if (ad == 5'd16) begin
      f = b[15];
      s = ck;
    end else begin
      f = a[ad - 5'd17];
      s = a[ad - 5'd16];
    end
    f = rv[0] ? ~s : f;
    return rv[6] ? {1'b1, ~f, f} : 3'b000;
  endfunction : mux_exp
  // program the mux, hold inputs, check the test pins
  task automatic mux_try(input logic [7:0] rv, input logic [15:0] a, input logic [15:0] b);
    wr(7'h18, rv);
    @(negedge clk);
    lvds_data_clock_in = 1'($urandom);
    port_a_lvds_in     = a;
    port_b_lvds_in     = b;
    repeat (8) @(negedge clk);
    check({13'h0, mux_exp(rv, lvds_data_clock_in, a, b)},
          {13'h0, test_output_pair_oe, test_output_pair_n, test_output_pair_p});
  endtask : mux_try
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b              = 1'b0;
    lvds_data_clock_in = 1'b0;
    port_a_lvds_in     = 16'h0000;
    port_b_lvds_in     = 16'h0000;
    void'($urandom(32'hc628));
    repeat (8) @(negedge clk);
    stat_chk(16'h004b);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    rdchk(7'h07, 8'h00);
    rdchk(7'h18, 8'h00);
    wr(7'h19, 8'h00);
    wr(7'h05, 8'hff);
    rdchk(7'h05, 8'h00);
    // every gain code, random disable bit
    for (int g = 0; g < 8; g++) begin
      v = {4'h0, 3'(g), 1'($urandom)};
      wr(7'h07, v);
      repeat (6) @(negedge clk);
      stat_chk({4'h0, v[0], v[3:1], pct_tab[g]});
      rdchk(7'h07, v);
    end
    mux_try(8'h60, 16'h5555, 16'haaaa);
    mux_try(8'h60, 16'h1555, 16'h2aaa);
    mux_try(8'h60, 16'h2aaa, 16'h1555);
    mux_try(8'h61, 16'h0555, 16'h02aa);
    mux_try(8'h61, 16'haaaa, 16'h5555);
    // boundary pair addresses then random ones, both selects
    for (int i = 0; i < 16; i++) begin
      for (int s = 0; s < 2; s++) begin
        r = {1'b0, (i != 15), (i < 6) ? ad_tab[i] : 5'($urandom), 1'(s)};
        mux_try(r, 16'($urandom), 16'($urandom));
        rdchk(7'h18, r);
      end
    end
    host_i.xfer(1'b0, 7'h18, 8'h7f, 15, rd);
    rdchk(7'h18, r);
    mux_try(8'h00, 16'($urandom), 16'($urandom));
    wr(7'h07, 8'h0d);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    stat_chk(16'h004b);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    rdchk(7'h07, 8'h00);
    summarize();
  end
endmodule : lvds_skew_test_mux_ctrl_tb
